// ### dv/fcs_array_model.sv
// behavioural flash array behind the sequencer
// assumes one-cycle orders and combinational reads
module fcs_array_model
    import fcs_pkg::*;
(
    input  wire logic        clock,
    input  wire fcs_arr_s    arrayCmd,
    input  wire logic [15:0] rdAddr,
    output logic [7:0]       rdData
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:65535]; // cells, erased state is FF

    initial
    begin
        foreach (mem[i])
            mem[i] = 8'hFF;
    end

    assign rdData = mem[rdAddr];

    // programming only clears bits, as real cells do
    always @(posedge clock)
    begin
        if (arrayCmd.prog)
            mem[arrayCmd.addr] <= mem[arrayCmd.addr] & arrayCmd.data;
        if (arrayCmd.sect)
            for (int i = 0; i < 4096; i++)
                mem[{arrayCmd.addr[15:12], i[11:0]}] <= 8'hFF;
        if (arrayCmd.chip)
            foreach (mem[i])
                mem[i] <= 8'hFF;
    end
endmodule

// ### dv/fcs_seq_chk.sv
// port checker of the flash command sequencer
// assumes one clock domain and async high reset
module fcs_seq_chk
    import fcs_pkg::*;
#(
    parameter int PROG_CYCLES  = 8,
    parameter int ERASE_CYCLES = 20
)
(
    input wire logic       clock,
    input wire logic       rst,
    input wire fcs_mode_e  mode,
    input wire logic [3:0] seqEnable,
    input wire fcs_bus_s   bus,
    input wire fcs_arr_s   arrayCmd,
    input wire logic [7:0] rdData,
    input wire logic       rdValid,
    input wire logic       busy,
    input wire logic       protectOn,
    input wire logic       parReadBlock,
    input wire logic       serLoadBlock
);
    timeunit 1ns;
    timeprecision 1ns;
    int   busyCnt;  // busy cycles of the running operation
    logic busyQ;    // busy one cycle ago
    logic longOp;   // running operation is an erase
    logic fresh;    // no read seen yet while busy
    logic lastTog;  // bit 6 of the last answered read
    logic chipRun;  // chip erase not yet settled
    wire  start  = busy && !busyQ;
    wire  isFirst = start || fresh;
    wire  anyCmd = arrayCmd.prog | arrayCmd.sect | arrayCmd.chip;

    // helper state for the timing, toggle and protection checks
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            busyCnt <= 0;
            busyQ   <= 1'b0;
            longOp  <= 1'b0;
            fresh   <= 1'b0;
            lastTog <= 1'b0;
            chipRun <= 1'b0;
        end
        else
        begin
            busyCnt <= busy ? busyCnt + 1 : 0;
            busyQ   <= busy;
            longOp  <= start ? (arrayCmd.sect | arrayCmd.chip) : longOp;
            fresh   <= busy && isFirst && !bus.rd;
            lastTog <= rdValid ? rdData[TOG_BIT] : lastTog;
            chipRun <= arrayCmd.chip ? 1'b1 : ((!busy && !busyQ) ? 1'b0 : chipRun);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_order;
        anyCmd;
    endsequence
    sequence s_first_rd;
        bus.rd && busy && isFirst;
    endsequence

    a_cmd_needs_write: assert property (s_order |-> $past(bus.wr) && !$past(busy)
        && $past(seqEnable) == SEQ_ON) else $error("order without enabled write");
    a_cmd_starts_busy: assert property (s_order |-> start)
        else $error("order without busy start");
    a_cmd_one_cycle: assert property (s_order |=> !anyCmd)
        else $error("order longer than a cycle");
    a_prog_data: assert property (arrayCmd.prog |-> arrayCmd.data == $past(bus.data))
        else $error("program data differs");
    a_sect_align: assert property (arrayCmd.sect |-> arrayCmd.addr[11:0] == 12'h000)
        else $error("sector address not aligned");
    a_par_no_sect: assert property (arrayCmd.sect |-> $past(mode) != MODE_PAR)
        else $error("sector erase in parallel mode");
    a_busy_length: assert property ($fell(busy) |->
        busyCnt == (longOp ? ERASE_CYCLES : PROG_CYCLES)) else $error("busy length");
    a_read_answer: assert property (rdValid == $past(bus.rd))
        else $error("read answer timing");
    a_first_toggle: assert property (s_first_rd |=> rdData[TOG_BIT])
        else $error("first toggle read not one");
    a_toggle_flip: assert property (bus.rd && busy && !isFirst |=> rdData[TOG_BIT] != lastTog)
        else $error("toggle bit did not flip");
    a_block_flags: assert property (parReadBlock == $past(protectOn && mode == MODE_PAR)
        && serLoadBlock == $past(protectOn && mode == MODE_SERIAL))
        else $error("block flags wrong");
    a_prot_kept: assert property (protectOn && !chipRun |=> protectOn)
        else $error("protection lost");
endmodule

bind fcs_sequencer fcs_seq_chk #(
    .PROG_CYCLES  (PROG_CYCLES),
    .ERASE_CYCLES (ERASE_CYCLES)
) u_chk (
    .clock        (clock),
    .rst          (rst),
    .mode         (mode),
    .seqEnable    (seqEnable),
    .bus          (bus),
    .arrayCmd     (arrayCmd),
    .rdData       (rdData),
    .rdValid      (rdValid),
    .busy         (busy),
    .protectOn    (protectOn),
    .parReadBlock (parReadBlock),
    .serLoadBlock (serLoadBlock)
);

// ### dv/tb_fcs_sequencer.sv
// self-checking bench of the flash command sequencer
// assumes the array model answers reads in the same cycle
module tb_fcs_sequencer
    import fcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] MK = 8'h6B; // arbitrary value
    localparam logic [7:0] MC = 8'h2D; // arbitrary value
    typedef struct {fcs_mode_e m; logic b; logic [15:0] a; logic [7:0] d;
        logic [15:0] pa;} fcs_row_s;
    fcs_row_s rows [4] = '{
        '{MODE_MCU, 1'b0, 16'h1234, 8'h5A, 16'h1234},
        '{MODE_MCU, 1'b1, 16'hF0FF, 8'h3C, 16'hF0FF},
        '{MODE_SERIAL, 1'b0, 16'h9000, 8'h11, 16'h1000},
        '{MODE_SERIAL, 1'b1, 16'h8001, 8'h22, 16'h8001}};
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    fcs_mode_e  mode = MODE_MCU;
    logic [3:0] seqEnable = SEQ_OFF;
    logic       bankSel = 1'b0;
    fcs_bus_s   bus = '0;
    logic [7:0] arrayRdata, rdData, q, p;
    fcs_arr_s   arrayCmd;
    logic       rdValid, busy, idMode, protectOn, parReadBlock, serLoadBlock;
    int         n_mismatch = 0;
    int         compares = 0;
    int         cyc = 0;

    always #2 clock = ~clock;

    fcs_sequencer #(.PROG_CYCLES(8), .ERASE_CYCLES(20), .ARRAY_KB(60), .MAKER_ID(MK),
        .MACRO_ID(MC)) u_dut (.clock(clock), .rst(rst), .mode(mode), .seqEnable(seqEnable),
        .bankSel(bankSel), .bus(bus), .arrayRdata(arrayRdata), .arrayCmd(arrayCmd),
        .rdData(rdData), .rdValid(rdValid), .busy(busy), .idMode(idMode),
        .protectOn(protectOn), .parReadBlock(parReadBlock), .serLoadBlock(serLoadBlock));
    fcs_array_model u_arr (.clock(clock), .arrayCmd(arrayCmd), .rdAddr(bus.addr),
        .rdData(arrayRdata));

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // cuts a hang short
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one bus write, held for one sampling edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clock);
        bus <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a);
        @(posedge clock);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h00};
        @(posedge clock);
        bus <= '0;
        #1;
        chk(rdValid, 1'b1);
        q = rdData;
    endtask
    task automatic ul(input logic [7:0] d);
        wr({4'h0, ADR_UNL1}, D_UNL1);
        wr({4'h0, ADR_UNL2}, D_UNL2);
        wr({4'h0, ADR_UNL1}, d);
    endtask
    task automatic erase(input logic [15:0] a, input logic [7:0] d);
        ul(D_ERASE);
        wr({4'h0, ADR_UNL1}, D_UNL1);
        wr({4'h0, ADR_UNL2}, D_UNL2);
        wr(a, d);
    endtask
    // polls until two reads of one address agree
    task automatic poll(input logic [15:0] a);
        int n;
        n = 0;
        rd(a);
        p = q;
        rd(a);
        while (q !== p && n < 60)
        begin
            p = q;
            rd(a);
            n++;
        end
        chk(busy, 1'b0);
    endtask
    task automatic setMode(input fcs_mode_e m);
        @(posedge clock);
        mode <= m;
        repeat (2) @(posedge clock);
        #1;
    endtask

    initial
    begin
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        chk({busy, idMode, protectOn, rdValid}, 4'h0);
        ul(D_PROG);
        wr(16'h2000, 8'h00);
        chk(busy, 1'b0);
        @(posedge clock);
        seqEnable <= SEQ_ON;
        $display("reset and disabled test done");
        ul(D_IDIN);
        chk(idMode, 1'b1);
        rd(ADR_SIZE);
        chk(q, SIZE_60K);
        wr(16'h3456, D_IDOUT);
        chk(idMode, 1'b0);
        rd(ADR_MAKER);
        chk(q, 8'hFF);
        wr(16'hF555, D_UNL1);
        wr(16'hFAAA, D_UNL2);
        wr(16'hF555, D_IDIN);
        rd(ADR_MAKER);
        chk(q, MK);
        rd(ADR_MACRO);
        chk(q, MC);
        rd(ADR_PROT);
        chk(q, PROT_OFF);
        ul(D_IDOUT);
        chk(idMode, 1'b0);
        // a stray third write must drop the half-entered program sequence
        wr({4'h0, ADR_UNL1}, D_UNL1);
        wr({4'h0, ADR_UNL2}, D_UNL2);
        wr(16'h0123, 8'h77);
        wr({4'h0, ADR_UNL1}, D_PROG);
        wr(16'h1FFF, D_SECT);
        chk({busy, idMode, arrayCmd.prog}, 3'h0);
        $display("identification and stray test done");
        foreach (rows[i])
        begin
            @(posedge clock);
            mode <= rows[i].m;
            bankSel <= rows[i].b;
            ul(D_PROG);
            wr(rows[i].a, rows[i].d);
            chk(arrayCmd.prog, 1'b1);
            chk(arrayCmd.addr, rows[i].pa);
            chk(arrayCmd.data, rows[i].d);
            rd(rows[i].a);
            chk(q[6], 1'b1);
            rd(16'h0000);
            chk(q[6], 1'b0);
            poll(rows[i].a);
            setMode(MODE_MCU);
            rd(rows[i].pa);
            chk(q, rows[i].d);
            $display("program row %0d done", i);
        end
        erase(16'h1FFF, D_SECT);
        chk(arrayCmd.sect, 1'b1);
        chk(arrayCmd.addr, 16'h1000);
        poll(16'h1000);
        rd(16'h1234);
        chk(q, 8'hFF);
        rd(16'hF0FF);
        chk(q, 8'h3C);
        setMode(MODE_PAR);
        erase(16'h8000, D_SECT);
        chk(busy, 1'b0);
        // protect runs in serial mode, bank 1 still selected by the last row
        setMode(MODE_SERIAL);
        $display("sector erase test done");
        ul(D_PROT);
        wr(ADR_PROT, D_PROTV);
        chk(busy, 1'b1);
        rd(ADR_PROT);
        chk(q[6], 1'b1);
        poll(ADR_PROT);
        ul(D_IDIN);
        rd(ADR_PROT);
        chk(q == PROT_OFF, 1'b0);
        wr(16'h0000, D_IDOUT);
        chk(protectOn, 1'b1);
        setMode(MODE_PAR);
        chk(parReadBlock, 1'b1);
        setMode(MODE_SERIAL);
        chk(serLoadBlock, 1'b1);
        setMode(MODE_MCU);
        erase(16'h8000, D_SECT);
        poll(16'h8001);
        chk(protectOn, 1'b1);
        erase({4'h0, ADR_UNL1}, D_CHIP);
        chk(arrayCmd.chip, 1'b1);
        poll(16'h8001);
        chk(protectOn, 1'b0);
        rd(16'hF0FF);
        chk(q, 8'hFF);
        $display("protect and chip erase test done");
        // a byte programmed before may be written again once erased
        ul(D_PROG);
        wr(16'h1234, 8'h96);
        chk(arrayCmd.addr, 16'h1234);
        poll(16'h1234);
        rd(16'h1234);
        chk(q, 8'h96);
        $display("reprogram after erase test done");
        tally_and_finish();
    end
endmodule

// ### verilog/fcs_pkg.sv
// shared constants and types of the flash command sequencer
// assumes a single 250 MHz clock shared by the cpu bus and the array macro
package fcs_pkg;
    // clock period in ns
    localparam int CLK_NS = 4;
    // longest byte program and protect time, in ns
    localparam int PROG_NS = 40000;
    // longest sector or chip erase time, in ns
    localparam int ERASE_NS = 30000000;
    // longest times round down to whole cycles
    localparam int PROG_CYC = PROG_NS / CLK_NS;
    localparam int ERASE_CYC = ERASE_NS / CLK_NS;
    // busy counter width, wide enough for the erase count
    localparam int CNT_W = 23;

    // unlock addresses, low 12 bits only
    localparam logic [11:0] ADR_UNL1 = 12'h555;
    localparam logic [11:0] ADR_UNL2 = 12'hAAA;
    // protect status address, all 16 bits
    localparam logic [15:0] ADR_PROT = 16'hFF7F;
    // identification addresses
    localparam logic [15:0] ADR_MAKER = 16'hF000;
    localparam logic [15:0] ADR_MACRO = 16'hF001;
    localparam logic [15:0] ADR_SIZE = 16'hF002;
    // serial bank 0 window offset (9xxx maps to 1xxx)
    localparam logic [15:0] BANK0_OFS = 16'h8000;

    // command data bytes
    localparam logic [7:0] D_UNL1 = 8'hAA;
    localparam logic [7:0] D_UNL2 = 8'h55;
    localparam logic [7:0] D_PROG = 8'hA0;
    localparam logic [7:0] D_ERASE = 8'h80;
    localparam logic [7:0] D_SECT = 8'h30;
    localparam logic [7:0] D_CHIP = 8'h10;
    localparam logic [7:0] D_IDIN = 8'h90;
    localparam logic [7:0] D_IDOUT = 8'hF0;
    localparam logic [7:0] D_PROT = 8'hA5;
    localparam logic [7:0] D_PROTV = 8'h00;

    // identification read values
    localparam logic [7:0] PROT_OFF = 8'hFF;
    localparam logic [7:0] PROT_ON = 8'h00;
    localparam logic [7:0] SIZE_60K = 8'h0E;
    localparam logic [7:0] SIZE_48K = 8'h0B;
    localparam logic [7:0] SIZE_32K = 8'h07;
    localparam logic [7:0] SIZE_24K = 8'h05;
    localparam logic [7:0] SIZE_16K = 8'h03;
    localparam logic [7:0] SIZE_8K = 8'h01;
    localparam logic [7:0] SIZE_4K = 8'h00;

    // sequence enable field values
    localparam logic [3:0] SEQ_ON = 4'h3;
    localparam logic [3:0] SEQ_OFF = 4'hC;
    // bit position of the toggle bit
    localparam int TOG_BIT = 6;

    // operating mode of the chip
    typedef enum logic [1:0] {
        MODE_MCU    = 2'b00,
        MODE_SERIAL = 2'b01,
        MODE_PAR    = 2'b10
    } fcs_mode_e;

    // cpu bus cycle towards the flash area
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } fcs_bus_s;

    // order to the array macro
    typedef struct packed {
        logic        prog;
        logic        sect;
        logic        chip;
        logic [15:0] addr;
        logic [7:0]  data;
    } fcs_arr_s;
endpackage

// ### verilog/fcs_sequencer.sv
// flash command sequencer: decodes unlock sequences from cpu writes,
// orders the array macro, times busy periods and shapes read data
// assumes the array returns read data combinationally for cpu addr,
// all inputs are on the same clock, and the array does the physical work
module fcs_sequencer
    import fcs_pkg::*;
#(
    parameter int PROG_CYCLES  = PROG_CYC,  // program and protect time
    parameter int ERASE_CYCLES = ERASE_CYC, // sector and chip erase time
    parameter int ARRAY_KB     = 60,        // array size in kbytes
    parameter logic [7:0] MAKER_ID = 8'h5A, // arbitrary value
    parameter logic [7:0] MACRO_ID = 8'hC3  // arbitrary value
)
(
    input  wire logic        clock,        // system clock
    input  wire logic        rst,          // async reset, high
    input  wire fcs_mode_e   mode,         // chip operating mode
    input  wire logic [3:0]  seqEnable,    // sequence enable field
    input  wire logic        bankSel,      // serial bank select
    input  wire fcs_bus_s    bus,          // cpu cycle
    input  wire logic [7:0]  arrayRdata,   // array read data
    output fcs_arr_s         arrayCmd,     // order to array macro
    output logic [7:0]       rdData,       // cpu read data
    output logic             rdValid,      // read data valid
    output logic             busy,         // operation running
    output logic             idMode,       // identification mode
    output logic             protectOn,    // read protection set
    output logic             parReadBlock, // parallel reads blocked
    output logic             serLoadBlock  // serial loaders refused
);

    // decoder and operation states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0000,
        ST_U1    = 4'b0001,
        ST_U2    = 4'b0010,
        ST_PROG  = 4'b0011,
        ST_E3    = 4'b0100,
        ST_E4    = 4'b0101,
        ST_E5    = 4'b0110,
        ST_PROT  = 4'b0111,
        ST_BUSY  = 4'b1000
    } fcs_state_e;

    // kind of running operation
    typedef enum logic [1:0] {
        OP_PROG  = 2'b00,
        OP_SECT  = 2'b01,
        OP_CHIP  = 2'b10,
        OP_PROT  = 2'b11
    } fcs_op_e;

    fcs_state_e         state;      // decoder state
    fcs_state_e         next_state; // decoder next state
    fcs_op_e            op;         // running operation
    fcs_op_e            next_op;    // operation to start
    logic [CNT_W-1:0]   busyCnt;    // cycles left in operation
    logic               togPhase;   // next toggle bit value
    logic               start;      // an operation begins
    fcs_arr_s           next_cmd;   // array order to issue

    // write qualified by the enable field
    wire seqOk = (seqEnable == SEQ_ON);
    wire wrOk = bus.wr & seqOk;
    // address and data matches, low 12 bits only
    wire isU1 = (bus.addr[11:0] == ADR_UNL1) & (bus.data == D_UNL1);
    wire isU2 = (bus.addr[11:0] == ADR_UNL2) & (bus.data == D_UNL2);
    wire at555 = (bus.addr[11:0] == ADR_UNL1);
    // protect confirm uses the full address
    wire isProtV = (bus.addr == ADR_PROT) & (bus.data == D_PROTV);
    // sector erase allowed outside parallel mode
    wire sectOk = (mode != MODE_PAR);

    // cpu address mapped to the physical array address
    wire bank0 = (mode == MODE_SERIAL) & ~bankSel;
    wire [15:0] physAddr = bank0 ? bus.addr - BANK0_OFS : bus.addr;

    // capacity code from the array size
    wire [7:0] sizeCode =
        (ARRAY_KB >= 60) ? SIZE_60K :
        (ARRAY_KB >= 48) ? SIZE_48K :
        (ARRAY_KB >= 32) ? SIZE_32K :
        (ARRAY_KB >= 24) ? SIZE_24K :
        (ARRAY_KB >= 16) ? SIZE_16K :
        (ARRAY_KB >= 8)  ? SIZE_8K  : SIZE_4K;

    // identification read value
    wire [7:0] protStat = protectOn ? PROT_ON : PROT_OFF;
    wire [7:0] idData =
        (bus.addr == ADR_MAKER) ? MAKER_ID :
        (bus.addr == ADR_MACRO) ? MACRO_ID :
        (bus.addr == ADR_SIZE)  ? sizeCode :
        (bus.addr == ADR_PROT)  ? protStat : arrayRdata;

    // array data with the toggle bit substituted while busy
    wire [7:0] togData =
        {arrayRdata[7], togPhase, arrayRdata[TOG_BIT-1:0]};

    // read data selection
    wire [7:0] readSel = busy ? togData :
        idMode ? idData : arrayRdata;

    // end of the running operation
    wire opDone = busy & (busyCnt == '0);

    // busy length for the operation being started
    wire [CNT_W-1:0] opLen = (next_op == OP_SECT || next_op == OP_CHIP)
        ? CNT_W'(ERASE_CYCLES - 1) : CNT_W'(PROG_CYCLES - 1);

    // identification mode entry and exit requests
    logic idEnter; // identification entry seen
    logic idExit;  // identification exit seen

    // sequence decoder
    always_comb
    begin
        next_state = state;
        next_op = op;
        next_cmd = '0;
        start = 1'b0;
        idEnter = 1'b0;
        idExit = 1'b0;
        if (state == ST_BUSY)
        begin
            // writes during an operation are ignored
            if (opDone)
                next_state = ST_IDLE;
        end
        else if (wrOk)
        begin
            // a stray write drops back to the idle state
            next_state = ST_IDLE;
            unique case (state)
                ST_IDLE:
                begin
                    if (isU1)
                        next_state = ST_U1;
                    else if (bus.data == D_IDOUT)
                        idExit = 1'b1;
                end
                ST_U1:
                begin
                    if (isU2)
                        next_state = ST_U2;
                end
                ST_U2:
                begin
                    // third write picks the command
                    if (at555 && bus.data == D_PROG)
                        next_state = ST_PROG;
                    else if (at555 && bus.data == D_ERASE)
                        next_state = ST_E3;
                    else if (at555 && bus.data == D_IDIN)
                        idEnter = 1'b1;
                    else if (at555 && bus.data == D_IDOUT)
                        idExit = 1'b1;
                    else if (at555 && bus.data == D_PROT)
                        next_state = ST_PROT;
                end
                ST_PROG:
                begin
                    // fourth write carries target and value
                    next_state = ST_BUSY;
                    next_op = OP_PROG;
                    start = 1'b1;
                    next_cmd.prog = 1'b1;
                    next_cmd.addr = physAddr;
                    next_cmd.data = bus.data;
                end
                ST_E3:
                begin
                    if (isU1)
                        next_state = ST_E4;
                end
                ST_E4:
                begin
                    if (isU2)
                        next_state = ST_E5;
                end
                ST_E5:
                begin
                    if (bus.data == D_SECT && sectOk)
                    begin
                        // sector picked by top nibble only
                        next_state = ST_BUSY;
                        next_op = OP_SECT;
                        start = 1'b1;
                        next_cmd.sect = 1'b1;
                        next_cmd.addr = {physAddr[15:12], 12'h000};
                    end
                    else if (at555 && bus.data == D_CHIP)
                    begin
                        next_state = ST_BUSY;
                        next_op = OP_CHIP;
                        start = 1'b1;
                        next_cmd.chip = 1'b1;
                    end
                end
                ST_PROT:
                begin
                    if (isProtV)
                    begin
                        next_state = ST_BUSY;
                        next_op = OP_PROT;
                        start = 1'b1;
                    end
                end
                default:
                    next_state = ST_IDLE;
            endcase
        end
    end

    // decoder state and operation kind
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            op <= OP_PROG;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
        end
    end

    // busy flag and countdown
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
            busyCnt <= '0;
        end
        else if (start)
        begin
            busy <= 1'b1;
            busyCnt <= opLen;
        end
        else if (opDone)
            busy <= 1'b0;
        else if (busy)
            busyCnt <= busyCnt - 1'b1;
    end

    // toggle bit: 1 on first read, inverted per read
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            togPhase <= 1'b1;
        else if (start)
            togPhase <= 1'b1;
        else if (busy && bus.rd)
            togPhase <= ~togPhase;
    end

    // identification mode flag
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            idMode <= 1'b0;
        else if (idEnter)
            idMode <= 1'b1;
        else if (idExit)
            idMode <= 1'b0;
    end

    // protection: set by protect, cleared only by chip erase
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            protectOn <= 1'b0;
        else if (opDone && op == OP_PROT)
            protectOn <= 1'b1;
        else if (opDone && op == OP_CHIP)
            protectOn <= 1'b0;
    end

    // protection gates towards the loaders
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            parReadBlock <= 1'b0;
            serLoadBlock <= 1'b0;
        end
        else
        begin
            parReadBlock <= protectOn & (mode == MODE_PAR);
            serLoadBlock <= protectOn & (mode == MODE_SERIAL);
        end
    end

    // one-cycle order to the array macro
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            arrayCmd <= '0;
        else
            arrayCmd <= next_cmd;
    end

    // registered read data
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rdData <= '0;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= bus.rd;
            if (bus.rd)
                rdData <= readSel;
        end
    end

endmodule
